// ==== logic/usbfa_pkg.sv ====
// Shared constants and carrier types for the USB function address/power block
package usbfa_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_FUNC_ADDRESS = 8'h00;
   localparam logic [7:0] ADDR_POWER = 8'h01;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h02;
   localparam logic [7:0] ADDR_STATUS = 8'h03;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_FUNC_ADDRESS = 8'h00;
   localparam logic [7:0] RST_POWER = 8'h10;
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h06;
   localparam logic [7:0] DATA_ZERO = 8'h00;
   localparam logic [6:0] ADDR_ZERO = 7'h00;

   // ==========================================================
   // Field positions
   localparam int FA_UPDATE_BIT = 7;
   localparam int FA_ADDR_MSB = 6;
   localparam int PW_ISO_UPDATE_BIT = 7;
   localparam int PW_INHIBIT_BIT = 4;
   localparam int PW_BUS_RESET_BIT = 3;
   localparam int PW_RESUME_BIT = 2;
   localparam int PW_SUSP_MODE_BIT = 1;
   localparam int PW_SUSP_EN_BIT = 0;
   localparam int IE_SUSPEND_BIT = 0;
   localparam int IE_RESUME_BIT = 1;
   localparam int IE_BUS_RESET_BIT = 2;

   // ==========================================================
   // Timing: core reset stays asserted this many clocks after request
   localparam int RST_SYNC_STAGES = 2;

   // ==========================================================
   // Suspend/resume state, Gray coded in declaration order only
   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b00,
      ST_SUSPENDED = 2'b01,
      ST_WAKE_DRIVE = 2'b11,
      ST_RESUMED = 2'b10
   } usbfa_state_type;

   // Events reported by the link logic, one-cycle pulses except bus_reset
   typedef struct packed {
      logic bus_reset;
      logic suspend;
      logic resume;
      logic sof;
      logic transfer_done;
      logic iso_pkt_loaded;
      logic iso_in_token;
   } usbfa_bus_ev_type;

   // Side effects of a detected bus reset, one-cycle pulses
   typedef struct packed {
      logic fifo_flush;
      logic csr_clear;
      logic index_clear;
      logic irq_enable_all;
   } usbfa_rst_fx_type;

endpackage

// ==== logic/usbfa_rst_gen.sv ====
// Core reset generator: async assert, synchronous release
`timescale 1ns/100ps
`default_nettype none
module usbfa_rst_gen
   import usbfa_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_req_rst_n,
   output logic o_core_rst_n
);
   import usbfa_pkg::*;

   // ==========================================================
   // Release chain
   wire rst_any_n;
   wire [RST_SYNC_STAGES-1:0] stage_in;
   logic [RST_SYNC_STAGES-1:0] chain_r;

   // Either source asserts at once, no clock needed
   assign rst_any_n = i_rst_n & i_req_rst_n;
   // First stage loads a constant one, the rest shift it along
   assign stage_in = {chain_r[RST_SYNC_STAGES-2:0], 1'b1};

   genvar g;
   generate
      for (g = 0; g < RST_SYNC_STAGES; g++)
      begin : g_stage
         always_ff @(posedge i_clock or negedge rst_any_n)
         begin
            if (!rst_any_n)
               chain_r[g] <= 1'b0;
            else
               chain_r[g] <= stage_in[g];
         end
      end
   endgenerate

   assign o_core_rst_n = chain_r[RST_SYNC_STAGES-1];

endmodule // usbfa_rst_gen
`default_nettype wire

// ==== logic/usbfa_ctrl.sv ====
// USB function address and device power control
`timescale 1ns/100ps
`default_nettype none
module usbfa_ctrl
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire usbfa_pkg::usbfa_bus_ev_type i_bus_ev,
   input wire logic i_common_interrupt_flags_read,
   output logic [6:0] o_func_addr,
   output logic o_core_inhibit,
   output logic o_suspend,
   output logic o_osc_wake,
   output logic o_resume_drive,
   output usbfa_pkg::usbfa_rst_fx_type o_rst_fx,
   output logic o_bus_reset_irq,
   output logic o_suspend_irq,
   output logic o_resume_irq,
   output logic o_iso_send,
   output logic o_iso_zlp
);
   import usbfa_pkg::*;

   // ==========================================================
   // Decode helpers
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ==========================================================
   // Declarations
   logic core_rst_n;
   logic req_r;
   logic req_nxt;
   logic [6:0] addr_stored_r;
   logic [6:0] addr_stored_nxt;
   logic [6:0] addr_active_r;
   logic [6:0] addr_active_nxt;
   logic update_r;
   logic update_nxt;
   logic iso_update_r;
   logic inhibit_r;
   logic inhibit_nxt;
   logic bus_reset_flag_r;
   logic bus_reset_d_r;
   logic resume_bit_r;
   logic resume_bit_nxt;
   logic susp_en_r;
   logic ie_susp_r;
   logic ie_resume_r;
   logic ie_reset_r;
   logic ie_resume_nxt;
   logic ie_reset_nxt;
   usbfa_state_type state_r;
   usbfa_state_type state_nxt;
   logic iso_ready_r;
   logic iso_ready_nxt;
   logic iso_held_r;
   logic iso_held_nxt;
   logic [7:0] rdata_r;
   logic susp_irq_r;
   logic res_irq_r;
   logic rst_irq_r;
   logic osc_wake_r;
   logic send_r;
   logic zlp_r;
   logic suspend_r;
   usbfa_rst_fx_type fx_r;
   usbfa_rst_fx_type fx_nxt;

   // ==========================================================
   // Bus slave decode
   wire wr_function_address = i_wr & hit(i_addr, ADDR_FUNC_ADDRESS);
   wire wr_power = i_wr & hit(i_addr, ADDR_POWER);
   wire wr_ie = i_wr & hit(i_addr, ADDR_IRQ_ENABLE);
   wire rd_function_address = hit(i_addr, ADDR_FUNC_ADDRESS);
   wire rd_power = hit(i_addr, ADDR_POWER);
   wire rd_ie = hit(i_addr, ADDR_IRQ_ENABLE);
   wire rd_status = hit(i_addr, ADDR_STATUS);

   wire live = ~inhibit_r;
   wire ev_reset_lvl = live & i_bus_ev.bus_reset;
   wire ev_reset = ev_reset_lvl & ~bus_reset_d_r;
   wire ev_suspend = live & i_bus_ev.suspend;
   wire ev_resume = live & i_bus_ev.resume;
   wire ev_sof = live & i_bus_ev.sof;
   wire ev_done = live & i_bus_ev.transfer_done;
   wire ev_loaded = live & i_bus_ev.iso_pkt_loaded;
   wire ev_token = live & i_bus_ev.iso_in_token;

   wire wr_resume_1 = wr_power & i_wdata[PW_RESUME_BIT];
   wire wr_resume_0 = wr_power & ~i_wdata[PW_RESUME_BIT];
   wire susp_flag = (state_r != ST_ACTIVE);

   // ==========================================================
   // Core reset request
   // core reset request
   assign req_nxt = wr_power & i_wdata[PW_BUS_RESET_BIT];

   // Request flop sits on power-on reset only, so the core reset
   // it causes cannot cut its own pulse short
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         req_r <= 1'b0;
      else
         req_r <= req_nxt;
   end

   usbfa_rst_gen u_rst_gen
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_req_rst_n(~req_r),
      .o_core_rst_n(core_rst_n)
   );

   // ==========================================================
   // Function address
   // stored address
   assign addr_stored_nxt = ev_reset ? ADDR_ZERO :
                            wr_function_address ? i_wdata[FA_ADDR_MSB:0] :
                            addr_stored_r;
   // pending bit, a new write wins over the completion
   assign update_nxt = ev_reset ? 1'b0 :
                       wr_function_address ? 1'b1 :
                       ev_done ? 1'b0 :
                       update_r;
   assign addr_active_nxt = ev_reset ? ADDR_ZERO :
                            (ev_done & update_r) ? addr_stored_r :
                            addr_active_r;

   // ==========================================================
   // Power control fields
   // only resets set inhibit
   assign inhibit_nxt = (wr_power & ~i_wdata[PW_INHIBIT_BIT]) ? 1'b0 :
                        inhibit_r;
   assign resume_bit_nxt = wr_resume_0 ? 1'b0 :
                           (wr_resume_1 & (state_r == ST_SUSPENDED)) ? 1'b1 :
                           resume_bit_r;

   assign ie_resume_nxt = ev_reset ? 1'b1 :
                          wr_ie ? i_wdata[IE_RESUME_BIT] : ie_resume_r;
   assign ie_reset_nxt = ev_reset ? 1'b1 :
                         wr_ie ? i_wdata[IE_BUS_RESET_BIT] : ie_reset_r;

   assign fx_nxt = {4{ev_reset}};

   // ==========================================================
   // Suspend and resume sequencing
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_ACTIVE:
         begin
            if (ev_suspend & susp_en_r & ~ev_reset)
               state_nxt = ST_SUSPENDED;
         end
         ST_SUSPENDED:
         begin
            if (ev_reset)
               state_nxt = ST_ACTIVE;
            else if (ev_resume)
               state_nxt = ST_RESUMED;
            else if (wr_resume_1)
               state_nxt = ST_WAKE_DRIVE;
         end
         ST_WAKE_DRIVE:
         begin
            if (ev_reset | wr_resume_0)
               state_nxt = ST_ACTIVE;
         end
         ST_RESUMED:
         begin
            if (ev_reset | i_common_interrupt_flags_read)
               state_nxt = ST_ACTIVE;
         end
         default:
            state_nxt = ST_ACTIVE;
      endcase
   end
   wire leave_susp = (state_r == ST_SUSPENDED) & (state_nxt != ST_SUSPENDED);

   // ==========================================================
   // Isochronous IN gating
   // Load and token together: token sees old state, load waits
   wire iso_go = ev_token & iso_ready_r & ~iso_held_r;
   wire iso_zlp_now = ev_token & iso_update_r & ~(iso_ready_r & ~iso_held_r);
   assign iso_held_nxt = (ev_loaded & iso_update_r) ? 1'b1 :
                         ev_sof ? 1'b0 :
                         iso_held_r;
   assign iso_ready_nxt = ev_loaded ? 1'b1 :
                          iso_go ? 1'b0 :
                          iso_ready_r;

   // ==========================================================
   // Read mux
   wire [7:0] function_address_view = {update_r, addr_stored_r};
   wire [7:0] power_view = {iso_update_r, 2'b00, inhibit_r,
                            bus_reset_flag_r, resume_bit_r,
                            susp_flag, susp_en_r};
   wire [7:0] ie_view = {5'b00000, ie_reset_r, ie_resume_r, ie_susp_r};
   wire [7:0] status_view = {iso_held_r, addr_active_r};
   wire [7:0] rd_mux = rd_function_address ? function_address_view :
                       rd_power ? power_view :
                       rd_ie ? ie_view :
                       rd_status ? status_view :
                       DATA_ZERO;
   wire [7:0] rdata_nxt = i_rd ? rd_mux : DATA_ZERO;

   // ==========================================================
   // Registers on the core reset
   // all registers except req_r to defaults
   always_ff @(posedge i_clock or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         addr_stored_r <= RST_FUNC_ADDRESS[FA_ADDR_MSB:0];
         addr_active_r <= RST_FUNC_ADDRESS[FA_ADDR_MSB:0];
         update_r <= RST_FUNC_ADDRESS[FA_UPDATE_BIT];
      end
      else
      begin
         addr_stored_r <= addr_stored_nxt;
         addr_active_r <= addr_active_nxt;
         update_r <= update_nxt;
      end
   end

   always_ff @(posedge i_clock or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         iso_update_r <= RST_POWER[PW_ISO_UPDATE_BIT];
         inhibit_r <= RST_POWER[PW_INHIBIT_BIT];
         bus_reset_flag_r <= RST_POWER[PW_BUS_RESET_BIT];
         bus_reset_d_r <= 1'b0;
         resume_bit_r <= RST_POWER[PW_RESUME_BIT];
         susp_en_r <= RST_POWER[PW_SUSP_EN_BIT];
      end
      else
      begin
         if (wr_power)
            iso_update_r <= i_wdata[PW_ISO_UPDATE_BIT];
         if (wr_power)
            susp_en_r <= i_wdata[PW_SUSP_EN_BIT];
         inhibit_r <= inhibit_nxt;
         bus_reset_flag_r <= ev_reset_lvl;
         bus_reset_d_r <= ev_reset_lvl;
         resume_bit_r <= resume_bit_nxt;
      end
   end

   always_ff @(posedge i_clock or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         ie_susp_r <= RST_IRQ_ENABLE[IE_SUSPEND_BIT];
         ie_resume_r <= RST_IRQ_ENABLE[IE_RESUME_BIT];
         ie_reset_r <= RST_IRQ_ENABLE[IE_BUS_RESET_BIT];
         state_r <= ST_ACTIVE;
         suspend_r <= 1'b0;
         iso_ready_r <= 1'b0;
         iso_held_r <= 1'b0;
      end
      else
      begin
         if (wr_ie)
            ie_susp_r <= i_wdata[IE_SUSPEND_BIT];
         ie_resume_r <= ie_resume_nxt;
         ie_reset_r <= ie_reset_nxt;
         state_r <= state_nxt;
         suspend_r <= (state_nxt == ST_SUSPENDED);
         iso_ready_r <= iso_ready_nxt;
         iso_held_r <= iso_held_nxt;
      end
   end

   // ==========================================================
   // Output pulses and read data
   always_ff @(posedge i_clock or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         rdata_r <= DATA_ZERO;
         fx_r <= '0;
         rst_irq_r <= 1'b0;
         susp_irq_r <= 1'b0;
         res_irq_r <= 1'b0;
         osc_wake_r <= 1'b0;
         send_r <= 1'b0;
         zlp_r <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         fx_r <= fx_nxt;
         rst_irq_r <= ev_reset & ie_reset_nxt;
         susp_irq_r <= (state_r == ST_ACTIVE) &
                       (state_nxt == ST_SUSPENDED) & ie_susp_r;
         res_irq_r <= ie_resume_r &
                      (((state_r == ST_SUSPENDED) & ev_resume & ~ev_reset) |
                       ((state_r == ST_WAKE_DRIVE) & wr_resume_0 &
                        ~ev_reset));
         osc_wake_r <= leave_susp;
         send_r <= iso_go;
         zlp_r <= iso_zlp_now;
      end
   end

   // ==========================================================
   // Output drive
   assign o_rdata = rdata_r;
   assign o_func_addr = addr_active_r;
   assign o_core_inhibit = inhibit_r;
   assign o_suspend = suspend_r;
   assign o_osc_wake = osc_wake_r;
   assign o_resume_drive = resume_bit_r;
   assign o_rst_fx = fx_r;
   assign o_bus_reset_irq = rst_irq_r;
   assign o_suspend_irq = susp_irq_r;
   assign o_resume_irq = res_irq_r;
   assign o_iso_send = send_r;
   assign o_iso_zlp = zlp_r;

endmodule // usbfa_ctrl
`default_nettype wire

// ==== tb/usbfa_host_model.sv ====
// Bus-side host model that issues link events to the control block
`timescale 1ns/100ps
`default_nettype none
module usbfa_host_model
   import usbfa_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire usbfa_pkg::usbfa_bus_ev_type i_req,
   output usbfa_pkg::usbfa_bus_ev_type o_ev
);
   // ==========================================================
   // Event launch
   // Registered so every event leaves on a clean edge, never mid-cycle
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_ev <= '0;
      end
      else
      begin
         o_ev <= i_req;
      end
   end
endmodule // usbfa_host_model
`default_nettype wire

// ==== tb/usbfa_ctrl_chk.sv ====
// Port-level checker for the function address and power control block
`timescale 1ns/100ps
`default_nettype none
module usbfa_ctrl_chk
   import usbfa_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire usbfa_pkg::usbfa_bus_ev_type i_bus_ev,
   input wire logic i_common_interrupt_flags_read,
   input wire logic [6:0] o_func_addr,
   input wire logic o_core_inhibit,
   input wire logic o_suspend,
   input wire logic o_osc_wake,
   input wire logic o_resume_drive,
   input wire usbfa_pkg::usbfa_rst_fx_type o_rst_fx,
   input wire logic o_bus_reset_irq,
   input wire logic o_suspend_irq,
   input wire logic o_resume_irq,
   input wire logic o_iso_send,
   input wire logic o_iso_zlp
);
   import usbfa_pkg::*;
   // ==========================================================
   // Helpers
   // Software core reset wipes state, so it excuses sudden changes
   wire logic sw_rst;
   assign sw_rst = i_wr && (i_addr == ADDR_POWER) && i_wdata[PW_BUS_RESET_BIT];
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   // ==========================================================
   // Properties
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == DATA_ZERO)
      else $error("read data outside its slot");
   inhibit_sticky_a: assert property (
      !o_core_inhibit && !sw_rst && !$past(sw_rst) |=> !o_core_inhibit)
      else $error("inhibit set again without core reset");
   bus_reset_fx_a: assert property (
      $rose(i_bus_ev.bus_reset) && !o_core_inhibit
      |=> (&o_rst_fx) && o_bus_reset_irq && o_func_addr == ADDR_ZERO)
      else $error("bus reset side effects missing");
   suspend_cause_a: assert property (
      $rose(o_suspend) |-> $past(i_bus_ev.suspend))
      else $error("suspend entered without bus suspend");
   suspend_irq_a: assert property (
      o_suspend_irq |-> $past(i_bus_ev.suspend))
      else $error("suspend interrupt without cause");
   resume_exit_a: assert property (
      o_suspend && i_bus_ev.resume |=> !o_suspend && o_osc_wake)
      else $error("resume did not leave suspend");
   osc_wake_a: assert property (
      o_osc_wake |-> $past(o_suspend) && !o_suspend)
      else $error("oscillator wake without suspend exit");
   addr_change_a: assert property ($changed(o_func_addr) |->
      $past(i_bus_ev.transfer_done) || $past(i_bus_ev.bus_reset)
      || $past(sw_rst) || $past(sw_rst, 2))
      else $error("address changed before transfer end");
   iso_zlp_a: assert property (
      o_iso_zlp |-> $past(i_bus_ev.iso_in_token))
      else $error("zero-length packet without token");
   iso_send_a: assert property (
      o_iso_send |-> $past(i_bus_ev.iso_in_token))
      else $error("iso packet sent without token");
   wake_drive_a: assert property ($rose(o_resume_drive) |->
      $past(i_wr && i_addr == ADDR_POWER && i_wdata[PW_RESUME_BIT] && o_suspend))
      else $error("resume drive without write while suspended");
endmodule // usbfa_ctrl_chk
bind usbfa_ctrl usbfa_ctrl_chk u_usbfa_ctrl_chk (.i_clock, .i_rst_n, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .i_bus_ev, .i_common_interrupt_flags_read, .o_func_addr,
   .o_core_inhibit, .o_suspend, .o_osc_wake, .o_resume_drive, .o_rst_fx,
   .o_bus_reset_irq, .o_suspend_irq, .o_resume_irq, .o_iso_send, .o_iso_zlp);
`default_nettype wire

// ==== tb/tb.sv ====
// Register-level testbench for the function address and power block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import usbfa_pkg::*;
   // ==========================================================
   // Stimulus and observation
   localparam logic [6:0] EV_BRST = 7'h40;
   localparam logic [6:0] EV_SUSP = 7'h20;
   localparam logic [6:0] EV_RES = 7'h10;
   localparam logic [6:0] EV_SOF = 7'h08;
   localparam logic [6:0] EV_DONE = 7'h04;
   localparam logic [6:0] EV_LOAD = 7'h02;
   localparam logic [6:0] EV_TOK = 7'h01;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_common_interrupt_flags_read = 1'b0;
   usbfa_bus_ev_type req = '0;
   usbfa_bus_ev_type bus_ev;
   usbfa_rst_fx_type o_rst_fx;
   logic [7:0] o_rdata;
   logic [6:0] o_func_addr;
   logic o_core_inhibit, o_suspend, o_osc_wake, o_resume_drive;
   logic o_bus_reset_irq, o_suspend_irq, o_resume_irq, o_iso_send, o_iso_zlp;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #25 i_clock = ~i_clock;
   usbfa_host_model u_usbfa_host_model (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_req(req), .o_ev(bus_ev));
   usbfa_ctrl u_usbfa_ctrl (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_bus_ev(bus_ev), .i_common_interrupt_flags_read(i_common_interrupt_flags_read),
      .o_func_addr(o_func_addr), .o_core_inhibit(o_core_inhibit),
      .o_suspend(o_suspend), .o_osc_wake(o_osc_wake),
      .o_resume_drive(o_resume_drive), .o_rst_fx(o_rst_fx),
      .o_bus_reset_irq(o_bus_reset_irq), .o_suspend_irq(o_suspend_irq),
      .o_resume_irq(o_resume_irq), .o_iso_send(o_iso_send),
      .o_iso_zlp(o_iso_zlp));
   // ==========================================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   // Bus reset is a level, so it stays up until an empty event drops it
   task automatic fire(input logic [6:0] e);
      @(posedge i_clock);
      req <= usbfa_bus_ev_type'(e);
      @(posedge i_clock);
      req <= usbfa_bus_ev_type'(e & EV_BRST);
      @(posedge i_clock);
      #1;
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         test_done;
      end
   end
   // ==========================================================
   // Scenarios
   initial
   begin
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      rd(ADDR_FUNC_ADDRESS, RST_FUNC_ADDRESS);
      rd(ADDR_POWER, RST_POWER);
      rd(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE);
      rd(8'h05, DATA_ZERO);
      fire(EV_BRST);
      chk({4'h0, o_rst_fx}, 8'h00);
      fire(7'h00);
      rd(ADDR_POWER, RST_POWER);
      wr(ADDR_POWER, 8'h18);
      repeat (5) @(posedge i_clock);
      wr(ADDR_IRQ_ENABLE, 8'h07);
      wr(ADDR_POWER, 8'h11);
      chk({7'h00, o_core_inhibit}, 8'h01);
      wr(ADDR_POWER, 8'h01);
      wr(ADDR_POWER, 8'h11);
      rd(ADDR_POWER, 8'h01);
      chk({7'h00, o_core_inhibit}, 8'h00);
      wr(ADDR_IRQ_ENABLE, 8'h07);
      wr(ADDR_FUNC_ADDRESS, 8'h85);
      rd(ADDR_FUNC_ADDRESS, 8'h85);
      chk({1'b0, o_func_addr}, 8'h00);
      fire(EV_DONE);
      chk({1'b0, o_func_addr}, 8'h05);
      rd(ADDR_FUNC_ADDRESS, 8'h05);
      fire(EV_SUSP);
      chk({6'h00, o_suspend, o_suspend_irq}, 8'h03);
      rd(ADDR_POWER, 8'h03);
      fire(EV_RES);
      chk({5'h00, o_suspend, o_osc_wake, o_resume_irq}, 8'h03);
      rd(ADDR_POWER, 8'h03);
      @(posedge i_clock);
      i_common_interrupt_flags_read <= 1'b1;
      @(posedge i_clock);
      i_common_interrupt_flags_read <= 1'b0;
      rd(ADDR_POWER, 8'h01);
      fire(EV_SUSP);
      wr(ADDR_POWER, 8'h05);
      chk({6'h00, o_resume_drive, o_suspend}, 8'h02);
      wr(ADDR_POWER, 8'h01);
      chk({6'h00, o_resume_drive, o_resume_irq}, 8'h01);
      rd(ADDR_POWER, 8'h01);
      wr(ADDR_POWER, 8'h81);
      fire(EV_LOAD);
      fire(EV_TOK);
      chk({6'h00, o_iso_send, o_iso_zlp}, 8'h01);
      fire(EV_SOF);
      fire(EV_TOK);
      chk({6'h00, o_iso_send, o_iso_zlp}, 8'h02);
      wr(ADDR_POWER, 8'h01);
      fire(EV_LOAD);
      fire(EV_TOK);
      chk({6'h00, o_iso_send, o_iso_zlp}, 8'h02);
      fire(EV_TOK);
      chk({6'h00, o_iso_send, o_iso_zlp}, 8'h00);
      fire(EV_BRST);
      chk({3'h0, o_rst_fx, o_bus_reset_irq}, 8'h1f);
      chk({1'b0, o_func_addr}, 8'h00);
      rd(ADDR_POWER, 8'h09);
      rd(ADDR_FUNC_ADDRESS, 8'h00);
      fire(7'h00);
      rd(ADDR_POWER, 8'h01);
      wr(ADDR_FUNC_ADDRESS, 8'h22);
      wr(ADDR_POWER, 8'h09);
      repeat (5) @(posedge i_clock);
      rd(ADDR_POWER, RST_POWER);
      rd(ADDR_FUNC_ADDRESS, RST_FUNC_ADDRESS);
      test_done;
   end
endmodule // tb
`default_nettype wire
